// ==== hw/adcseq_regs.svh ====
`ifndef ADCSEQ_REGS_SVH
`define ADCSEQ_REGS_SVH
// Register byte addresses
`define ADCSEQ_SEL_ADDR      12'h000
`define ADCSEQ_CTRL_ADDR     12'h004
`define ADCSEQ_DATA_ADDR     12'h008
`define ADCSEQ_STAT_ADDR     12'h00C
// Selection register fields
`define ADCSEQ_SEL_CH_LSB    0
`define ADCSEQ_SEL_CH_MSB    3
`define ADCSEQ_SEL_REF_LSB   6
`define ADCSEQ_SEL_REF_MSB   7
// Control register fields
`define ADCSEQ_CTRL_EN_BIT   7
`define ADCSEQ_CTRL_SC_BIT   6
`define ADCSEQ_CTRL_FR_BIT   5
`define ADCSEQ_CTRL_DONE_BIT 4
`define ADCSEQ_CTRL_PS_LSB   0
`define ADCSEQ_CTRL_PS_MSB   2
// Reset values
`define ADCSEQ_SEL_RST       8'h00
`define ADCSEQ_CTRL_RST      8'h00
// Timing in half converter clock cycles
`define ADCSEQ_EXT_HALVES    6'd50
`define ADCSEQ_EXT_SH_HALVES 6'd27
`define ADCSEQ_NRM_HALVES    6'd26
`define ADCSEQ_NRM_SH_HALVES 6'd3
`define ADCSEQ_MAX_CODE      10'h3FF
`endif

// ==== hw/adcseq_pkg.sv ====
package adcseq_pkg;
    typedef enum logic [2:0] {
        ADCSEQ_IDLE = 3'b001,
        ADCSEQ_WAIT = 3'b010,
        ADCSEQ_CONV = 3'b100
    } adcseq_state_t;
    typedef struct packed {
        logic [1:0] reference_select;
        logic [3:0] channel_select;
    } adcseq_sel_t;
endpackage

// ==== hw/adcseq_core.sv ====
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "adcseq_regs.svh"
// Overview of operation
// - First conversion after enable lasts 25 cycles; sample-and-hold at 13.5.
// - Normal conversion lasts 13 cycles; sample-and-hold at 1.5.
// - Processor writes land in a holding selection register.
// - Idle: active selection copies holding register every cycle.
// - Active selection is frozen from conversion start.
// - Copying resumes in the last cycle before done flag sets.
// - Conversion begins at the next converter clock rising edge after start.
// - Selection written in a safe window applies to the next conversion.
// - Input above reference yields the maximum code.
// - Result written and done flag set together on completion.
// - Free-run restarts immediately after completion, start bit stays high.
// - Only first conversion after enable is extended.
module adcseq_core
    import adcseq_pkg::*;
#(
    parameter int DATA_W = 10
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [DATA_W-1:0] sar_code,
    input  wire logic              sar_over,
    output logic      [3:0]        mux_channel,
    output logic      [1:0]        mux_reference,
    output logic                   sample_hold,
    output logic                   converting
);
    logic                access;
    logic                wr;
    logic [31:0]         rdata;
    adcseq_sel_t         hold_q;
    adcseq_sel_t         act_q;
    logic                en_q;
    logic                sc_q;
    logic                fr_q;
    logic                done_q;
    logic [2:0]          ps_q;
    logic [DATA_W-1:0]   data_q;
    logic                first_q;
    adcseq_state_t       st_q;
    logic [5:0]          half_q;
    logic [7:0]          pre_q;
    logic                en_d;
    logic                tick_h;
    logic                last_h;
    logic                sc_set;
    logic [5:0]          len_h;
    logic [5:0]          sh_h;
    logic                sar_over_m;
    logic                sar_over_s;
    logic [DATA_W-1:0]   sar_code_m;
    logic [DATA_W-1:0]   sar_code_s;

    assign access = psel & penable & clk_en;
    assign wr     = access & pwrite;
    assign sc_set = wr && paddr == `ADCSEQ_CTRL_ADDR && pwdata[`ADCSEQ_CTRL_SC_BIT];
    assign len_h  = first_q ? `ADCSEQ_EXT_HALVES : `ADCSEQ_NRM_HALVES;
    assign sh_h   = first_q ? `ADCSEQ_EXT_SH_HALVES : `ADCSEQ_NRM_SH_HALVES;
    // Converter clock: half period = 2^ps pclk cycles; tick_h marks each half edge
    assign tick_h = (pre_q & ((8'd1 << ps_q) - 8'd1)) == ((8'd1 << ps_q) - 8'd1);
    // Enable as written this cycle, so enable and start in one write still start
    assign en_d   = (wr && paddr == `ADCSEQ_CTRL_ADDR) ? pwdata[`ADCSEQ_CTRL_EN_BIT] : en_q;
    assign last_h = (half_q >= len_h - 6'd2);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_over_m <= 1'b0;
            sar_over_s <= 1'b0;
            sar_code_m <= '0;
            sar_code_s <= '0;
        end else if (clk_en) begin
            sar_over_m <= sar_over;
            sar_over_s <= sar_over_m;
            sar_code_m <= sar_code;
            sar_code_s <= sar_code_m;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 8'h00;
        end else if (clk_en) begin
            if (!en_q) begin
                pre_q <= 8'h00;
            end else begin
                pre_q <= pre_q + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= adcseq_sel_t'(6'h00);
        end else if (wr && paddr == `ADCSEQ_SEL_ADDR) begin
            hold_q.reference_select <= pwdata[`ADCSEQ_SEL_REF_MSB:`ADCSEQ_SEL_REF_LSB];
            hold_q.channel_select   <= pwdata[`ADCSEQ_SEL_CH_MSB:`ADCSEQ_SEL_CH_LSB];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= adcseq_sel_t'(6'h00);
        end else if (clk_en) begin
            if (st_q != ADCSEQ_CONV) begin
                act_q <= hold_q;
            end else if (last_h) begin
                act_q <= hold_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= ADCSEQ_IDLE;
            half_q  <= 6'd0;
            first_q <= 1'b1;
            sc_q    <= 1'b0;
            done_q  <= 1'b0;
            data_q  <= '0;
        end else if (clk_en) begin
            if (wr && paddr == `ADCSEQ_CTRL_ADDR && pwdata[`ADCSEQ_CTRL_DONE_BIT]) begin
                done_q <= 1'b0;
            end
            if (!en_d) begin
                st_q    <= ADCSEQ_IDLE;
                first_q <= 1'b1;
                sc_q    <= 1'b0;
                half_q  <= 6'd0;
            end else begin
                if (sc_set) begin
                    sc_q <= 1'b1;
                end
                case (st_q)
                    ADCSEQ_IDLE: begin
                        if (sc_set) begin
                            st_q <= ADCSEQ_WAIT;
                        end
                    end
                    ADCSEQ_WAIT: begin
                        // Start on the next rising converter edge (counter wrap)
                        if (tick_h && pre_q[ps_q] == 1'b1) begin
                            st_q   <= ADCSEQ_CONV;
                            half_q <= 6'd0;
                        end
                    end
                    ADCSEQ_CONV: begin
                        if (tick_h) begin
                            if (half_q == len_h - 6'd1) begin
                                done_q  <= 1'b1;
                                first_q <= 1'b0;
                                half_q  <= 6'd0;
                                data_q  <= sar_over_s ? DATA_W'(`ADCSEQ_MAX_CODE)
                                                      : sar_code_s;
                                if (fr_q) begin
                                    st_q <= ADCSEQ_CONV;
                                end else begin
                                    st_q <= ADCSEQ_IDLE;
                                    sc_q <= 1'b0;
                                end
                            end else begin
                                half_q <= half_q + 6'd1;
                            end
                        end
                    end
                    default: st_q <= ADCSEQ_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            fr_q <= 1'b0;
            ps_q <= 3'h0;
        end else if (wr && paddr == `ADCSEQ_CTRL_ADDR) begin
            en_q <= pwdata[`ADCSEQ_CTRL_EN_BIT];
            fr_q <= pwdata[`ADCSEQ_CTRL_FR_BIT];
            ps_q <= pwdata[`ADCSEQ_CTRL_PS_MSB:`ADCSEQ_CTRL_PS_LSB];
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        if (paddr == `ADCSEQ_SEL_ADDR) begin
            rdata[`ADCSEQ_SEL_REF_MSB:`ADCSEQ_SEL_REF_LSB] = hold_q.reference_select;
            rdata[`ADCSEQ_SEL_CH_MSB:`ADCSEQ_SEL_CH_LSB]   = hold_q.channel_select;
        end else if (paddr == `ADCSEQ_CTRL_ADDR) begin
            rdata[`ADCSEQ_CTRL_EN_BIT]   = en_q;
            rdata[`ADCSEQ_CTRL_SC_BIT]   = sc_q;
            rdata[`ADCSEQ_CTRL_FR_BIT]   = fr_q;
            rdata[`ADCSEQ_CTRL_DONE_BIT] = done_q;
            rdata[`ADCSEQ_CTRL_PS_MSB:`ADCSEQ_CTRL_PS_LSB] = ps_q;
        end else if (paddr == `ADCSEQ_DATA_ADDR) begin
            rdata[DATA_W-1:0] = data_q;
        end else if (paddr == `ADCSEQ_STAT_ADDR) begin
            rdata[2:0] = st_q;
            rdata[13:8] = act_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                prdata  <= rdata;
                pslverr <= paddr != `ADCSEQ_SEL_ADDR && paddr != `ADCSEQ_CTRL_ADDR
                        && paddr != `ADCSEQ_DATA_ADDR && paddr != `ADCSEQ_STAT_ADDR;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mux_channel   <= 4'h0;
            mux_reference <= 2'h0;
            sample_hold   <= 1'b0;
            converting    <= 1'b0;
        end else if (clk_en) begin
            mux_channel   <= act_q.channel_select;
            mux_reference <= act_q.reference_select;
            sample_hold   <= st_q == ADCSEQ_CONV && half_q == sh_h && tick_h;
            converting    <= st_q == ADCSEQ_CONV;
        end
    end
endmodule // adcseq_core

// ==== testbench/adcseq_core_props.sv ====
`timescale 1ns/1ns
module adcseq_core_props #(
    parameter int DATA_W = 10
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              clk_en,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [DATA_W-1:0] sar_code,
    input wire logic              sar_over,
    input wire logic [3:0]        mux_channel,
    input wire logic [1:0]        mux_reference,
    input wire logic              sample_hold,
    input wire logic              converting
);
    logic [5:0] wsel_q;
    // Last selection written by the processor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wsel_q <= 6'h00;
        else if (psel && penable && pwrite && paddr == 12'h000) wsel_q <= {pwdata[7:6], pwdata[3:0]};
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_sh_delay: assert property (
        $rose(converting) |-> (##3 sample_hold) or (##27 sample_hold))
        else $error("sample instant misplaced");
    chk_sh_inside: assert property (sample_hold |-> converting)
        else $error("sample outside conversion");
    chk_sh_single: assert property (sample_hold |=> !sample_hold [*8])
        else $error("sample pulse repeated");
    chk_mux_locked: assert property (
        $rose(converting) |=> ($stable(mux_channel) && $stable(mux_reference)) [*8])
        else $error("selection moved during conversion");
    chk_idle_copy: assert property (
        psel && penable && pready && pwrite && paddr == 12'h000 && !converting
        |=> ##[0:2] ({mux_reference, mux_channel} == wsel_q || converting))
        else $error("idle selection not copied");
    chk_bus_answer: assert property (
        psel && !penable && clk_en |=> pready && (pslverr == (paddr > 12'h00C)))
        else $error("bus answer wrong");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
endmodule // adcseq_core_props
bind adcseq_core adcseq_core_props #(.DATA_W(DATA_W)) adcseq_core_props_i (.*);

// ==== testbench/adcseq_analog_model.sv ====
`timescale 1ns/1ns
module adcseq_analog_model (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [3:0] mux_channel,
    input wire logic [1:0] mux_reference,
    input wire logic       sample_hold,
    output logic     [9:0] sar_code,
    output logic           sar_over
);
    // Holds the sampled input until the next sample instant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_code <= 10'h000;
            sar_over <= 1'b0;
        end else if (sample_hold) begin
            sar_code <= {mux_channel, mux_reference, 4'hA};
            sar_over <= (mux_channel == 4'hF);
        end
    end
endmodule // adcseq_analog_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`include "adcseq_regs.svh"
module testbench;
    import adcseq_pkg::*;
    logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [9:0]  sar_code;
    logic [3:0]  mux_channel;
    logic [1:0]  mux_reference;
    logic        pready, pslverr, sar_over, sample_hold, converting, err;
    adcseq_sel_t cur_sel, nsel;
    int          errors = 0, samples_checked = 0, run_len = 0, last_len = 0;
    adcseq_core #(.DATA_W(10)) adcseq_core_i (.*);
    adcseq_analog_model adcseq_analog_model_i (.*);
    always #20 pclk = ~pclk;
    always @(negedge pclk) begin
        if (converting === 1'b1) run_len++;
        else if (run_len != 0) begin
            last_len = run_len;
            run_len = 0;
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function logic [9:0] exp_code(input adcseq_sel_t s);
        return (s.channel_select == 4'hF) ? 10'h3FF : {s.channel_select, s.reference_select, 4'hA};
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr_sel(input adcseq_sel_t s);
        apb(1'b1, `ADCSEQ_SEL_ADDR, {24'h0, s.reference_select, 2'b00, s.channel_select});
    endtask
    task wait_done;
        for (int n = 0; n < 60; n++) begin
            apb(1'b0, `ADCSEQ_CTRL_ADDR, 32'h0);
            if (rd[4] === 1'b1) break;
        end
        check(rd[4], 1'b1);
    endtask
    task read_result(input adcseq_sel_t s);
        apb(1'b0, `ADCSEQ_DATA_ADDR, 32'h0);
        check(rd[9:0], exp_code(s));
    endtask
    task run_conv(input int exp_len, input int frz);
        int n;
        apb(1'b1, `ADCSEQ_CTRL_ADDR, 32'hC0);
        for (n = 0; n < 30 && converting !== 1'b1; n++) @(negedge pclk);
        wr_sel(nsel);
        @(negedge pclk);
        check({mux_reference, mux_channel}, cur_sel);
        // Freeze mid-conversion; the run stretches by the frozen cycles
        if (frz != 0) begin
            @(posedge pclk);
            clk_en <= 1'b0;
            repeat (frz) @(posedge pclk);
            clk_en <= 1'b1;
        end
        for (n = 0; n < 100 && converting === 1'b1; n++) @(negedge pclk);
        @(negedge pclk);
        check(last_len, exp_len);
        apb(1'b0, `ADCSEQ_CTRL_ADDR, 32'h0);
        check(rd[6:4], 3'b001);
        read_result(cur_sel);
        check({mux_reference, mux_channel}, nsel);
        cur_sel = nsel;
        apb(1'b1, `ADCSEQ_CTRL_ADDR, 32'h90);
    endtask
    initial begin
        void'($urandom(32'h6e13));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADCSEQ_SEL_ADDR, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000);
        cur_sel = {2'b01, 4'($urandom_range(0, 14))};
        wr_sel(cur_sel);
        apb(1'b0, `ADCSEQ_SEL_ADDR, 32'h0);
        check(rd, {24'h0, cur_sel.reference_select, 2'b00, cur_sel.channel_select});
        check({mux_reference, mux_channel}, cur_sel);
        for (int i = 0; i < 4; i++) begin
            nsel = {($urandom_range(0, 1) ? 2'b11 : 2'b01),
                    ((i == 1) ? 4'hF : 4'($urandom_range(0, 14)))};
            run_conv((i == 0) ? 50 : ((i == 2) ? 36 : 26), (i == 2) ? 10 : 0);
        end
        apb(1'b1, `ADCSEQ_CTRL_ADDR, 32'h0);
        apb(1'b1, `ADCSEQ_CTRL_ADDR, 32'hC0);
        repeat (35) @(negedge pclk);
        apb(1'b1, `ADCSEQ_CTRL_ADDR, 32'h0);
        repeat (2) @(negedge pclk);
        check(converting, 1'b0);
        nsel = cur_sel;
        run_conv(50, 0);
        apb(1'b1, `ADCSEQ_CTRL_ADDR, 32'hE0);
        wait_done();
        nsel = {2'b11, 4'($urandom_range(0, 14))};
        wr_sel(nsel);
        read_result(cur_sel);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `ADCSEQ_CTRL_ADDR, 32'hF0);
            wait_done();
            check(rd[6], 1'b1);
            read_result((k == 0) ? cur_sel : nsel);
        end
        apb(1'b1, `ADCSEQ_CTRL_ADDR, 32'h0);
        print_verdict();
    end
endmodule // testbench
